// file: tgc_codec.sv
// tape group code codec: dual-clock fifo plus the link-side encoder/decoder
// assumes i_link_clock is the drive's write clock while writing and its
// read clock while reading, and that it runs while i_rst is high
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tgc_async_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    // filling side
    input  wire logic             i_wr_clock,
    input  wire logic             i_wr_rst,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // draining side
    input  wire logic             i_rd_clock,
    input  wire logic             i_rd_rst,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic      [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin;
    logic [AW:0]      wgray;
    logic [AW:0]      rbin;
    logic [AW:0]      rgray;
    logic [AW:0]      rgray_meta;
    logic [AW:0]      rgray_w;
    logic [AW:0]      wgray_meta;
    logic [AW:0]      wgray_r;
    logic [AW:0]      next_wbin;
    logic [AW:0]      next_rbin;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    assign next_wbin  = wbin + {{AW{1'b0}}, 1'b1};
    assign next_rbin  = rbin + {{AW{1'b0}}, 1'b1};
    assign o_wr_ready = (wgray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    assign o_rd_valid = (rgray != wgray_r);
    assign o_rd_data  = mem[rbin[AW-1:0]];

    always_ff @(posedge i_wr_clock)
    begin
        if (i_wr_valid && o_wr_ready)
        begin
            mem[wbin[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_wr_clock)
    begin
        if (i_wr_rst)
        begin
            wbin  <= '0;
            wgray <= '0;
        end
        else if (i_wr_valid && o_wr_ready)
        begin
            wbin  <= next_wbin;
            wgray <= to_gray(next_wbin);
        end
    end

    always_ff @(posedge i_wr_clock)
    begin
        if (i_wr_rst)
        begin
            rgray_meta <= '0;
            rgray_w    <= '0;
        end
        else
        begin
            rgray_meta <= rgray;
            rgray_w    <= rgray_meta;
        end
    end

    always_ff @(posedge i_rd_clock)
    begin
        if (i_rd_rst)
        begin
            rbin  <= '0;
            rgray <= '0;
        end
        else if (o_rd_valid && i_rd_ready)
        begin
            rbin  <= next_rbin;
            rgray <= to_gray(next_rbin);
        end
    end

    always_ff @(posedge i_rd_clock)
    begin
        if (i_rd_rst)
        begin
            wgray_meta <= '0;
            wgray_r    <= '0;
        end
        else
        begin
            wgray_meta <= wgray;
            wgray_r    <= wgray_meta;
        end
    end
endmodule // tgc_async_fifo

////////////////////////////////////////////////////////////////////////////////
module tgc_codec #(
    parameter int PRE_WORDS  = tgc_pkg::PRE_WORDS,
    parameter int FIFO_DEPTH = tgc_pkg::FIFO_DEPTH
) (
    // system side
    input  wire logic                   i_clock,
    input  wire logic                   i_rst,
    // link side
    input  wire logic                   i_link_clock,
    input  wire logic                   i_read_data,
    output logic                        o_write_flux,
    // mode control
    input  wire logic                   i_enable_n,
    input  wire tgc_pkg::tgc_mode_e     i_mode,
    input  wire logic                   i_ctrl_invalid,
    // nibbles to record
    input  wire logic                   i_wr_valid,
    output logic                        o_wr_ready,
    input  wire logic [3:0]             i_wr_nibble,
    // nibbles read back
    output logic                        o_rd_valid,
    input  wire logic                   i_rd_ready,
    output var tgc_pkg::tgc_rd_word_s   o_rd_word,
    // status
    output logic                        o_sync_mark,
    output logic                        o_byte_sync,
    output logic                        o_invalid,
    output logic                        o_rd_overrun
);
    localparam int         PW       = $clog2(PRE_WORDS + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRE_WORDS - 1);

    tgc_pkg::tgc_ctrl_s    ctrl_meta;
    tgc_pkg::tgc_ctrl_s    ctrl_sync;
    tgc_pkg::tgc_ctrl_s    ctrl_prev;
    tgc_pkg::tgc_ctrl_s    ctrl;
    tgc_pkg::tgc_state_e   state;
    tgc_pkg::tgc_rd_word_s rd_word;
    logic                  lrst_meta;
    logic                  link_rst;
    logic [4:0]            shreg;
    logic [4:0]            next_tx_word;
    logic [4:0]            next_word;
    logic [4:0]            dec;
    logic [2:0]            bit_cnt;
    logic [2:0]            zero_run;
    logic [PW-1:0]         pre_cnt;
    logic                  flux;
    logic                  invalid_flag;
    logic                  overrun;
    logic                  sync_tgl;
    logic                  rd_push;
    logic                  rf_ready;
    logic                  wf_valid;
    logic                  wf_pop;
    logic [3:0]            wf_data;
    logic [2:0]            status_lnk;
    logic [2:0]            status_meta;
    logic [2:0]            status;
    logic                  tgl_meta;
    logic                  tgl_s;
    logic                  tgl_d;
    logic                  wr_go;
    logic                  rd_go;
    logic                  is_write;
    logic                  is_read;
    logic                  word_end;
    logic                  tx_bit;

    ////////////////////////////////////////////////////////////////////////////
    // buffering and link-domain reset
    tgc_async_fifo #(.WIDTH(tgc_pkg::NIB_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .i_wr_clock (i_clock),
        .i_wr_rst   (i_rst),
        .i_wr_valid (i_wr_valid),
        .o_wr_ready (o_wr_ready),
        .i_wr_data  (i_wr_nibble),
        .i_rd_clock (i_link_clock),
        .i_rd_rst   (link_rst),
        .o_rd_valid (wf_valid),
        .i_rd_ready (wf_pop),
        .o_rd_data  (wf_data)
    );

    tgc_async_fifo #(.WIDTH(tgc_pkg::CODE_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
        .i_wr_clock (i_link_clock),
        .i_wr_rst   (link_rst),
        .i_wr_valid (rd_push),
        .o_wr_ready (rf_ready),
        .i_wr_data  (rd_word),
        .i_rd_clock (i_clock),
        .i_rd_rst   (i_rst),
        .o_rd_valid (o_rd_valid),
        .i_rd_ready (i_rd_ready),
        .o_rd_data  (o_rd_word)
    );

    always_ff @(posedge i_link_clock)
    begin
        lrst_meta <= i_rst;
        link_rst  <= lrst_meta;
        ctrl_meta <= '{i_enable_n, i_mode, i_ctrl_invalid};
        ctrl_sync <= ctrl_meta;
        ctrl_prev <= ctrl_sync;
    end

    // several control bits cross together: act only on two equal samples
    always_ff @(posedge i_link_clock)
    begin
        if (ctrl_sync == ctrl_prev)
            ctrl <= ctrl_prev;
    end

    ////////////////////////////////////////////////////////////////////////////
    // link-side sequencing
    assign wr_go     = !ctrl.enable_n && (ctrl.mode == tgc_pkg::TGC_MODE_WRITE);
    assign rd_go     = !ctrl.enable_n && (ctrl.mode == tgc_pkg::TGC_MODE_READ);
    assign is_write  = (state == tgc_pkg::ST_WPRE) || (state == tgc_pkg::ST_WMARK)
                    || (state == tgc_pkg::ST_WDATA);
    assign is_read   = (state == tgc_pkg::ST_RHUNT) || (state == tgc_pkg::ST_RSEEK)
                    || (state == tgc_pkg::ST_RDATA);
    assign word_end  = (bit_cnt == tgc_pkg::BIT_LAST);
    assign tx_bit    = shreg[tgc_pkg::CODE_W-1];
    assign next_word = {shreg[3:0], i_read_data};
    assign dec       = tgc_pkg::decode(next_word);
    assign wf_pop    = word_end && wr_go && wf_valid
                    && ((state == tgc_pkg::ST_WMARK) || (state == tgc_pkg::ST_WDATA));

    always_comb
    begin
        next_tx_word = tgc_pkg::SYNC_WORD;
        if (state == tgc_pkg::ST_WPRE)
        begin
            if (pre_cnt == PRE_LAST)
            begin
                next_tx_word = tgc_pkg::MARK_WORD;
            end
        end
        else if (wf_valid)
        begin
            next_tx_word = tgc_pkg::encode(wf_data);
        end
    end

    always_ff @(posedge i_link_clock)
    begin
        if (link_rst)
        begin
            state <= tgc_pkg::ST_IDLE;
        end
        else
        begin
            case (state)
                tgc_pkg::ST_IDLE:
                    if (wr_go)
                        state <= tgc_pkg::ST_WPRE;
                    else if (rd_go)
                        state <= tgc_pkg::ST_RHUNT;
                tgc_pkg::ST_WPRE:
                    if (word_end && !wr_go)
                        state <= tgc_pkg::ST_IDLE;
                    else if (word_end && (pre_cnt == PRE_LAST))
                        state <= tgc_pkg::ST_WMARK;
                tgc_pkg::ST_WMARK:
                    if (word_end)
                        state <= wr_go ? tgc_pkg::ST_WDATA : tgc_pkg::ST_IDLE;
                tgc_pkg::ST_WDATA:
                    if (word_end && !wr_go)
                        state <= tgc_pkg::ST_IDLE;
                tgc_pkg::ST_RHUNT:
                    if (!rd_go)
                        state <= tgc_pkg::ST_IDLE;
                    else if (next_word == tgc_pkg::SYNC_WORD)
                        state <= tgc_pkg::ST_RSEEK;
                tgc_pkg::ST_RSEEK:
                    if (!rd_go)
                        state <= tgc_pkg::ST_IDLE;
                    else if (next_word == tgc_pkg::MARK_WORD)
                        state <= tgc_pkg::ST_RDATA;
                tgc_pkg::ST_RDATA:
                    if (!rd_go)
                        state <= tgc_pkg::ST_IDLE;
                default:
                    state <= tgc_pkg::ST_IDLE;
            endcase
        end
    end

    // one register serves both directions
    always_ff @(posedge i_link_clock)
    begin
        if (link_rst)
            shreg <= '0;
        else if ((state == tgc_pkg::ST_IDLE) && wr_go)
            shreg <= tgc_pkg::SYNC_WORD;
        else if (is_write)
            shreg <= word_end ? next_tx_word : {shreg[3:0], shreg[4]};
        else if (is_read)
            shreg <= next_word;
    end

    always_ff @(posedge i_link_clock)
    begin
        if (link_rst || !(is_write || (state == tgc_pkg::ST_RDATA)))
            bit_cnt <= tgc_pkg::BIT_FIRST;
        else
            bit_cnt <= word_end ? tgc_pkg::BIT_FIRST : bit_cnt + 3'h1;
    end

    always_ff @(posedge i_link_clock)
    begin
        if (link_rst || (state != tgc_pkg::ST_WPRE))
            pre_cnt <= '0;
        else if (word_end)
            pre_cnt <= pre_cnt + PW'(1);
    end

    always_ff @(posedge i_link_clock)
    begin
        if (link_rst)
            flux <= 1'b0;
        else if (is_write && tx_bit)
            flux <= ~flux;
    end

    assign o_write_flux = flux;

    ////////////////////////////////////////////////////////////////////////////
    // read-side flags and words
    always_ff @(posedge i_link_clock)
    begin
        if (link_rst || !ctrl.ctrl_invalid)
            invalid_flag <= 1'b0;
        else if ((state == tgc_pkg::ST_RDATA) && word_end && !dec[4])
            invalid_flag <= 1'b1;
    end

    always_ff @(posedge i_link_clock)
    begin
        if (link_rst)
            sync_tgl <= 1'b0;
        else if (is_read && (next_word == tgc_pkg::SYNC_WORD))
            sync_tgl <= ~sync_tgl;
    end

    always_ff @(posedge i_link_clock)
    begin
        if (link_rst)
        begin
            rd_push <= 1'b0;
            rd_word <= '0;
        end
        else
        begin
            rd_push <= (state == tgc_pkg::ST_RDATA) && word_end && rd_go;
            rd_word <= '{!dec[4], dec[3:0]};
        end
    end

    // tape cannot be stalled, so a full read buffer drops the word
    always_ff @(posedge i_link_clock)
    begin
        if (link_rst || (state == tgc_pkg::ST_IDLE))
            overrun <= 1'b0;
        else if (rd_push && !rf_ready)
            overrun <= 1'b1;
    end

    always_ff @(posedge i_link_clock)
    begin
        if (link_rst)
            status_lnk <= '0;
        else
            status_lnk <= {state == tgc_pkg::ST_RDATA, invalid_flag, overrun};
    end

    ////////////////////////////////////////////////////////////////////////////
    // crossings into the system domain
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            status_meta <= '0;
            status      <= '0;
            tgl_meta    <= 1'b0;
            tgl_s       <= 1'b0;
            tgl_d       <= 1'b0;
            o_sync_mark <= 1'b0;
        end
        else
        begin
            status_meta <= status_lnk;
            status      <= status_meta;
            tgl_meta    <= sync_tgl;
            tgl_s       <= tgl_meta;
            tgl_d       <= tgl_s;
            o_sync_mark <= tgl_s ^ tgl_d;
        end
    end

    assign o_byte_sync  = status[2];
    assign o_invalid    = status[1];
    assign o_rd_overrun = status[0];

    ////////////////////////////////////////////////////////////////////////////
    // checks on the link side
    always_ff @(posedge i_link_clock)
    begin
        if (link_rst || !is_write || tx_bit)
            zero_run <= 3'h0;
        else
            zero_run <= zero_run + 3'h1;
    end

    default clocking cb @(posedge i_link_clock); endclocking
    // system reset also masks the checks before the synced reset is known
    default disable iff (link_rst || i_rst);

    a_encode_load: assert property (wf_pop |=> shreg == tgc_pkg::encode($past(wf_data)))
        else $error("data word not encoded from nibble");
    a_zero_limit: assert property (zero_run <= 3'h2)
        else $error("more than two zeros in a row");
    a_flux_hold: assert property ((is_write && !tx_bit) |=> $stable(flux))
        else $error("flux reversed on a zero bit");
    a_preamble_ones: assert property ((state == tgc_pkg::ST_WPRE) |-> tx_bit)
        else $error("preamble bit not one");
    a_mark_after_pre: assert property ($rose(state == tgc_pkg::ST_WMARK) |-> shreg == tgc_pkg::MARK_WORD && $past(state) == tgc_pkg::ST_WPRE)
        else $error("violation word not after preamble");
    a_mark_found: assert property ((state == tgc_pkg::ST_RSEEK && rd_go && next_word == tgc_pkg::MARK_WORD) |=> state == tgc_pkg::ST_RDATA)
        else $error("violation word not taken as byte sync");
    a_msb_order: assert property ((is_write && bit_cnt == tgc_pkg::BIT_FIRST) |-> ##4 (!is_write || tx_bit == $past(shreg[0], 4)))
        else $error("serial order not msb first");
    a_invalid_set: assert property ((state == tgc_pkg::ST_RDATA && word_end && !dec[4] && ctrl.ctrl_invalid && $stable(ctrl.ctrl_invalid)) |=> invalid_flag)
        else $error("invalid code not flagged");
    a_invalid_clear: assert property (!ctrl.ctrl_invalid |=> !invalid_flag)
        else $error("invalid flag not held reset");
    a_sync_detect: assert property ((is_read && next_word == tgc_pkg::SYNC_WORD) |=> sync_tgl != $past(sync_tgl))
        else $error("all-ones word missed");
    a_one_state: assert property ($onehot(state) && !(is_write && is_read))
        else $error("state not one-hot or modes overlap");

    c_write_data: cover property (state == tgc_pkg::ST_WMARK ##5 state == tgc_pkg::ST_WDATA);
    c_read_data: cover property (state == tgc_pkg::ST_RSEEK ##1 state == tgc_pkg::ST_RDATA);
    c_invalid: cover property ($rose(invalid_flag));
    c_overrun: cover property ($rose(overrun));
endmodule // tgc_codec

`default_nettype wire

// file: tgc_codec_tb.sv
// self-checking bench for the tape group code codec
// assumes tgc_pkg, tgc_codec and tgc_tape_model are compiled first
`timescale 1ns/100ps
`default_nettype none

module tgc_codec_tb;
    localparam int          PRE   = 2;
    localparam logic [79:0] CODES = {5'h0f, 5'h0e, 5'h0d, 5'h1e, 5'h0b, 5'h0a, 5'h09, 5'h1a,
                                     5'h17, 5'h16, 5'h15, 5'h1d, 5'h13, 5'h12, 5'h1b, 5'h19};
    logic                  clock      = 1'b0;
    logic                  link_clock = 1'b0;
    logic                  rst        = 1'b1;
    logic                  enable_n   = 1'b1;
    tgc_pkg::tgc_mode_e    mode       = tgc_pkg::TGC_MODE_HOLD;
    logic                  ctrl_inv   = 1'b0;
    logic                  wr_valid   = 1'b0;
    logic [3:0]            wr_nibble  = 4'h0;
    logic                  rd_ready   = 1'b0;
    logic                  wr_ready, rd_valid, sync_mark, byte_sync, invalid, overrun;
    logic                  read_data, write_flux;
    tgc_pkg::tgc_rd_word_s rd_word;
    int                    err_total  = 0;
    int                    n_compared = 0;

    always #50 clock = ~clock;
    initial
    begin
        #13;
        forever #40 link_clock = ~link_clock;
    end

    tgc_codec #(.PRE_WORDS(PRE), .FIFO_DEPTH(16)) uut (
        .i_clock(clock), .i_rst(rst), .i_link_clock(link_clock),
        .i_read_data(read_data), .o_write_flux(write_flux),
        .i_enable_n(enable_n), .i_mode(mode), .i_ctrl_invalid(ctrl_inv),
        .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .i_wr_nibble(wr_nibble),
        .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_word(rd_word),
        .o_sync_mark(sync_mark), .o_byte_sync(byte_sync), .o_invalid(invalid),
        .o_rd_overrun(overrun));
    tgc_tape_model tape (.i_link_clock(link_clock), .i_write_flux(write_flux),
                         .o_read_data(read_data));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // fill the buffer, see a refusal, then record and read back the flux
    task automatic test_write;
        int   k;
        int   s;
        int   run;
        logic exp[$];
        for (k = 0; k < 16; k++)
        begin
            wr_valid  <= 1'b1;
            wr_nibble <= k[3:0];
            @(posedge clock);
            chk(wr_ready === 1'b1, "buffer refused early");
        end
        wr_nibble <= 4'h5;
        repeat (2) @(posedge clock);
        chk(wr_ready === 1'b0, "buffer not full");
        wr_valid <= 1'b0;
        tape.cap = 1'b1;
        enable_n <= 1'b0;
        mode     <= tgc_pkg::TGC_MODE_WRITE;
        repeat (200) @(posedge clock);
        tape.cap = 1'b0;
        mode     <= tgc_pkg::TGC_MODE_HOLD;
        enable_n <= 1'b1;
        for (k = 0; k < PRE * 5; k++)
            exp.push_back(1'b1);
        exp = {exp, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (k = 0; k < 80; k++)
            exp.push_back(CODES[(k / 5) * 5 + 4 - (k % 5)]);
        s = 0;
        while (s < tape.rx.size() && tape.rx[s] !== 1'b1)
            s++;
        chk(tape.rx.size() >= s + exp.size(), "too few bits recorded");
        for (k = 0; k < exp.size() && s + k < tape.rx.size(); k++)
            chk(tape.rx[s + k] === exp[k], "recorded bit wrong");
        run = 0;
        for (k = s; k < tape.rx.size(); k++)
        begin
            run = (tape.rx[k] === 1'b0) ? run + 1 : 0;
            chk(run <= 2, "zero run too long");
        end
        repeat (20) @(posedge clock);
        $display("test_write done");
    endtask

    // play a block from tape and check sync, words and the invalid flag
    task automatic test_read;
        int                    k;
        int                    got;
        int                    cnt;
        int                    ns;
        bit                    bs;
        bit                    moved;
        logic                  f0;
        tgc_pkg::tgc_rd_word_s w[16];
        ctrl_inv <= 1'b1;
        enable_n <= 1'b0;
        mode     <= tgc_pkg::TGC_MODE_READ;
        repeat (5) @(posedge clock);
        for (k = 0; k < 15; k++)
            tape.play.push_back(1'b1);
        tape.play = {tape.play, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (k = 0; k < 75; k++)
            tape.play.push_back(CODES[(k / 5) * 5 + 4 - (k % 5)]);
        for (k = 0; k < 5; k++)
            tape.play.push_back(1'b0);
        f0       = write_flux;
        got      = 0;
        cnt      = 0;
        ns       = 0;
        bs       = 0;
        moved    = 0;
        rd_ready <= 1'b1;
        while (got < 16 && cnt < 2000)
        begin
            @(posedge clock);
            cnt++;
            ns = ns + (sync_mark === 1'b1);
            bs = bs | (byte_sync === 1'b1);
            moved = moved | (write_flux !== f0);
            if (rd_valid === 1'b1)
            begin
                w[got] = rd_word;
                got++;
            end
        end
        rd_ready <= 1'b0;
        chk(got == 16, "too few words read");
        chk(ns > 0, "no sync mark");
        chk(bs, "no byte sync");
        chk(!moved, "flux moved while reading");
        for (k = 0; k < 15; k++)
            chk(w[k] === {1'b0, k[3:0]}, "decoded word wrong");
        chk(w[15].invalid === 1'b1, "bad code not marked");
        repeat (5) @(posedge clock);
        chk(invalid === 1'b1, "invalid flag not set");
        ctrl_inv <= 1'b0;
        repeat (10) @(posedge clock);
        chk(invalid === 1'b0, "invalid flag not held clear");
        // reader keeps pushing words while nobody pops: the buffer must overflow
        repeat (80) @(posedge clock);
        chk(overrun === 1'b1, "dropped word not flagged");
        mode     <= tgc_pkg::TGC_MODE_HOLD;
        enable_n <= 1'b1;
        repeat (20) @(posedge clock);
        chk(overrun === 1'b0, "overrun not cleared in idle");
        chk(byte_sync === 1'b0, "byte sync kept after read");
        $display("test_read done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        test_write();
        test_read();
        test_done();
    end

    initial
    begin
        #3000000;
        err_total++;
        test_done();
    end
endmodule // tgc_codec_tb
`default_nettype wire

// file: tgc_pkg.sv
// constants, types and code tables shared by the tape group code codec
// assumes nothing beyond a SystemVerilog compiler
package tgc_pkg;

    localparam int          CODE_W     = 5;
    localparam int          NIB_W      = 4;
    localparam int          PRE_WORDS  = 8;
    localparam int          FIFO_DEPTH = 16;
    localparam logic [4:0]  SYNC_WORD  = 5'h1f;
    localparam logic [4:0]  MARK_WORD  = 5'h07;
    localparam logic [2:0]  BIT_FIRST  = 3'h0;
    localparam logic [2:0]  BIT_LAST   = 3'h4;

    typedef enum logic [1:0] {
        TGC_MODE_READ  = 2'h0,
        TGC_MODE_WRITE = 2'h1,
        TGC_MODE_HOLD  = 2'h2,
        TGC_MODE_SPARE = 2'h3
    } tgc_mode_e;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_WPRE  = 7'h02,
        ST_WMARK = 7'h04,
        ST_WDATA = 7'h08,
        ST_RHUNT = 7'h10,
        ST_RSEEK = 7'h20,
        ST_RDATA = 7'h40
    } tgc_state_e;

    typedef struct packed {
        logic      enable_n;
        tgc_mode_e mode;
        logic      ctrl_invalid;
    } tgc_ctrl_s;

    typedef struct packed {
        logic             invalid;
        logic [NIB_W-1:0] nibble;
    } tgc_rd_word_s;

    // nibble to five-bit code, msb recorded first
    function automatic logic [4:0] encode(input logic [3:0] nib);
        logic [4:0] w;
        w = 5'h19;
        case (nib)
            4'h0:    w = 5'h19;
            4'h1:    w = 5'h1b;
            4'h2:    w = 5'h12;
            4'h3:    w = 5'h13;
            4'h4:    w = 5'h1d;
            4'h5:    w = 5'h15;
            4'h6:    w = 5'h16;
            4'h7:    w = 5'h17;
            4'h8:    w = 5'h1a;
            4'h9:    w = 5'h09;
            4'ha:    w = 5'h0a;
            4'hb:    w = 5'h0b;
            4'hc:    w = 5'h1e;
            4'hd:    w = 5'h0d;
            4'he:    w = 5'h0e;
            default: w = 5'h0f;
        endcase
        return w;
    endfunction

    // five-bit code to {valid, nibble}
    function automatic logic [4:0] decode(input logic [4:0] w);
        logic [4:0] r;
        r = 5'h00;
        case (w)
            5'h19:   r = 5'h10;
            5'h1b:   r = 5'h11;
            5'h12:   r = 5'h12;
            5'h13:   r = 5'h13;
            5'h1d:   r = 5'h14;
            5'h15:   r = 5'h15;
            5'h16:   r = 5'h16;
            5'h17:   r = 5'h17;
            5'h1a:   r = 5'h18;
            5'h09:   r = 5'h19;
            5'h0a:   r = 5'h1a;
            5'h0b:   r = 5'h1b;
            5'h1e:   r = 5'h1c;
            5'h0d:   r = 5'h1d;
            5'h0e:   r = 5'h1e;
            5'h0f:   r = 5'h1f;
            default: r = 5'h00;
        endcase
        return r;
    endfunction

endpackage

// file: tgc_tape_model.sv
// tape drive model: write amplifier capture and data separator playback
// assumes the codec launches flux and samples read data on rising link edges
`timescale 1ns/100ps
`default_nettype none

module tgc_tape_model (
    // link side
    input  wire logic i_link_clock,
    input  wire logic i_write_flux,
    output logic      o_read_data
);
    logic last_flux;
    bit   cap;
    logic play[$];
    logic rx[$];

    initial
    begin
        o_read_data = 1'b0;
        last_flux   = 1'b0;
        cap         = 1'b0;
    end

    always @(posedge i_link_clock)
    begin
        last_flux <= i_write_flux;
        // a reversal reads back as one, none as zero
        if (cap)
            rx.push_back(i_write_flux ^ last_flux);
        // idle line toggles so no stale level passes for data
        if (play.size() > 0)
            o_read_data <= play.pop_front();
        else
            o_read_data <= ~o_read_data;
    end
endmodule // tgc_tape_model
`default_nettype wire
